// [rtl/ubc_command_port.sv]
`timescale 1ns/10ps
module ubc_command_port
  import ubc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        cs_n_in,
  input  wire logic        wr_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [2:0]  fifo_select_in,
  input  wire logic [15:0] host_data_bus_in,
  output logic      [15:0] host_data_bus_out,
  output logic             host_data_bus_oe_out,
  output logic             ready_out,
  output logic             int_n_out,
  input  wire logic [5:0]  usb_event_in,
  output logic             fifo_wr_out,
  output logic             fifo_rd_out,
  output logic      [1:0]  fifo_sel_out,
  output logic      [15:0] fifo_wr_data_out,
  input  wire logic [15:0] fifo_rd_data_in,
  output logic      [7:0]  interface_configuration_out,
  output logic             default_config_out
);

  typedef enum logic [1:0] {PH_ADDR, PH_HI, PH_LO} ubc_phase_t;

  typedef struct packed {
    logic [PIN_W-1:0]  p1;
    logic [PIN_W-1:0]  p2;
    logic [PIN_W-1:0]  p3;
    logic [PIN_W-1:0]  pst;
    ubc_phase_t        phase;
    logic [5:0]        adr;
    logic [3:0]        hi;
    logic [3:0]        busy;
    logic              ready;
    logic              int_n;
    logic              rd_mode;
    logic [7:0]        rd_val;
    logic [IRQ_W-1:0]  stat;
    logic [63:0][7:0]  regs;
    logic [15:0]       dout;
    logic              doe;
    logic              fifo_wr;
    logic              fifo_rd;
    logic [1:0]        fsel;
    logic [15:0]       wdata;
    logic [7:0]        desc_cnt;
    logic              dflt;
  } ubc_state_t;

  localparam ubc_state_t RST_Q = '{
    p1: '1, p2: '1, p3: '1, pst: '1,
    phase: PH_ADDR, ready: 1'b1, int_n: 1'b1, dflt: 1'b1,
    default: '0};

  ubc_state_t        q;
  ubc_state_t        n;
  logic              cs_act;
  logic              wr_end;
  logic              rd_beg;
  logic              rd_end;
  logic              is_cmd;
  logic              is_fifo;
  logic              take;
  logic [7:0]        cbyte;
  logic [2:0]        sel;
  logic [IRQ_W-1:0]  irq_en;

  always_comb begin
    n = q;
    // Three stages; a change counts once stages two and three agree
    n.p1 = {oe_n_in, rd_n_in, wr_n_in, cs_n_in, fifo_select_in,
            host_data_bus_in};
    n.p2 = q.p1;
    n.p3 = q.p2;
    n.pst = (q.p3 & ~(q.p2 ^ q.p3)) | (q.pst & (q.p2 ^ q.p3));
    cs_act  = ~q.pst[PIN_CS];
    wr_end  = cs_act & ~q.pst[PIN_WR] & n.pst[PIN_WR];
    rd_beg  = cs_act & q.pst[PIN_RD] & ~n.pst[PIN_RD];
    rd_end  = cs_act & ~q.pst[PIN_RD] & n.pst[PIN_RD];
    sel     = q.pst[PIN_SEL +: 3];
    cbyte   = q.pst[7:0];
    irq_en  = q.regs[IRQ_EN_ADR][IRQ_W-1:0];
    is_cmd  = (sel == SEL_CMD);
    is_fifo = ~sel[2];
    // Bytes arriving while busy are dropped, master must wait
    take    = wr_end & is_cmd & q.ready;

    // Endpoint FIFO traffic bypasses the command engine
    n.fifo_wr = wr_end & is_fifo;
    n.fifo_rd = rd_beg & is_fifo;
    if (n.fifo_wr || n.fifo_rd) begin
      n.fsel = sel[1:0];
    end
    if (n.fifo_wr) begin
      n.wdata = q.pst[15:0];
    end
    if (n.fifo_rd) begin
      n.dout = fifo_rd_data_in;
    end

    if (q.busy != 4'h0) begin
      n.busy = q.busy - 4'h1;
      if (q.busy == 4'h1) begin
        n.ready = 1'b1;
      end
    end

    // Clear before a new request so a read taken in this cycle wins
    if (rd_end && is_cmd && q.rd_mode) begin
      n.rd_mode = 1'b0;
    end

    if (take) begin
      n.ready = 1'b0;
      n.busy  = READY_LOW_CNT;
      if (cbyte[CMD_TYPE_BIT]) begin
        n.adr = cbyte[5:0];
        if (cbyte[CMD_DIR_BIT]) begin
          n.rd_mode = 1'b1;
          n.phase   = PH_ADDR;
          n.rd_val  = (cbyte[5:0] == IRQ_STAT_ADR) ?
                      {2'h0, q.stat} : q.regs[cbyte[5:0]];
        end else begin
          n.phase = PH_HI;
        end
      end else begin
        unique case (q.phase)
          PH_HI: begin
            n.hi    = cbyte[3:0];
            n.phase = PH_LO;
          end
          PH_LO: begin
            n.regs[q.adr] = {q.hi, cbyte[3:0]};
            n.phase       = PH_ADDR;
            if (q.adr == DESC_ADR &&
                q.desc_cnt != DESC_CNT_MAX) begin
              n.desc_cnt = q.desc_cnt + 8'h01;
            end
          end
          PH_ADDR: begin
            // Stray data byte with no address: ignored
          end
        endcase
      end
    end

    // Longer download than the identity fields carries configuration
    n.dflt = (n.desc_cnt <= DESC_ID_BYTES);

    // Status clears when the master finishes reading it; events win
    n.stat = usb_event_in;
    if (!(rd_end && is_cmd && !q.rd_mode)) begin
      n.stat = n.stat | q.stat;
    end
    n.int_n = ~(n.rd_mode | (|(n.stat & irq_en)));
    if (is_cmd) begin
      n.dout = {8'h00, n.rd_mode ? n.rd_val : {2'h0, n.stat}};
    end
    n.doe = ~n.pst[PIN_CS] & ~n.pst[PIN_OE];
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      q <= RST_Q;
      q.regs[IFCFG_ADR] <= IFCFG_RST;
    end else begin
      q <= n;
    end
  end

  assign host_data_bus_out           = q.dout;
  assign host_data_bus_oe_out        = q.doe;
  assign ready_out                   = q.ready;
  assign int_n_out                   = q.int_n;
  assign fifo_wr_out                 = q.fifo_wr;
  assign fifo_rd_out                 = q.fifo_rd;
  assign fifo_sel_out                = q.fsel;
  assign fifo_wr_data_out            = q.wdata;
  assign interface_configuration_out = q.regs[IFCFG_ADR];
  assign default_config_out          = q.dflt;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  sequence busy_seq;
    !ready_out ##[4:8] ready_out;
  endsequence

  ready_drop_a: assert property (take |=> busy_seq)
    else $error("ready did not drop and recover after a byte");

  ready_hold_a: assert property (take |=> !ready_out [*4])
    else $error("ready returned too early");

  addr_latch_a: assert property (
    take && cbyte[7] && !cbyte[6] |=> q.adr == $past(cbyte[5:0])
      && q.phase == PH_HI)
    else $error("address byte not latched");

  read_int_a: assert property (
    take && cbyte[7] && cbyte[6] |=> !int_n_out && q.rd_mode)
    else $error("read request did not raise interrupt");

  hi_nibble_a: assert property (
    take && !cbyte[7] && q.phase == PH_HI
      |=> q.hi == $past(cbyte[3:0]) && q.regs == $past(q.regs))
    else $error("upper nibble mishandled");

  reg_write_a: assert property (
    take && !cbyte[7] && q.phase == PH_LO
      |=> q.regs[$past(q.adr)] == {$past(q.hi), $past(cbyte[3:0])})
    else $error("register write value wrong");

  irq_line_a: assert property (
    (|(usb_event_in & irq_en)) |=> !int_n_out)
    else $error("pending event not flagged");

  stat_bus_a: assert property (
    is_cmd && !q.rd_mode && !take |=>
      (host_data_bus_out[5:0] & $past(usb_event_in)) == $past(usb_event_in))
    else $error("status byte missing from data lines");

  fifo_sel_a: assert property (
    wr_end && is_fifo |=> fifo_wr_out && fifo_sel_out == $past(sel[1:0]))
    else $error("fifo write not routed");

  cmd_nofifo_a: assert property (
    (wr_end || rd_beg) && is_cmd |=> !fifo_wr_out && !fifo_rd_out)
    else $error("command access leaked to fifo");

  dflt_cfg_a: assert property (
    q.desc_cnt <= DESC_ID_BYTES |-> default_config_out)
    else $error("default configuration lost");

endmodule

// [rtl/ubc_pkg.sv]
// How it works
// - Command port takes descriptor downloads and register writes.
// - Command byte bit 7: one is address byte, zero is data byte.
// - Address byte bit 6: zero means write, one means read.
// - Address byte bits 5 to 0 give one of 64 registers.
// - Data byte carries only its low nibble; bits 6 to 4 ignored.
// - First data byte gives bits 7 to 4, second gives bits 3 to 0.
// - Ready drops after each taken command byte, rises when free again.
// - Interrupt line flags events enabled in the interrupt enable register, or read data ready in read mode.
// - Identity-only descriptor download keeps default configuration.
// - Select lines pick one endpoint FIFO or the command port.
// - With the command port selected and outside read mode, pending event status byte sits on the low data lines; in read mode they carry the read value.
package ubc_pkg;
  localparam int          CLK_NS        = 4;
  localparam int          READY_LOW_NS  = 20;
  localparam int          READY_LOW_CYC =
    (READY_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  READY_LOW_CNT = 4'(READY_LOW_CYC);
  // Pin vector layout after synchronising
  localparam int          PIN_W         = 23;
  localparam int          PIN_SEL       = 16;
  localparam int          PIN_CS        = 19;
  localparam int          PIN_WR        = 20;
  localparam int          PIN_RD        = 21;
  localparam int          PIN_OE        = 22;
  localparam logic [2:0]  SEL_CMD       = 3'h4;
  localparam int          CMD_TYPE_BIT  = 7;
  localparam int          CMD_DIR_BIT   = 6;
  // Register addresses
  localparam logic [5:0]  IFCFG_ADR     = 6'h01;
  localparam logic [5:0]  IRQ_EN_ADR    = 6'h02;
  localparam logic [5:0]  IRQ_STAT_ADR  = 6'h03;
  localparam logic [5:0]  DESC_ADR      = 6'h30;
  localparam logic [7:0]  IFCFG_RST     = 8'h00;
  localparam logic [7:0]  DESC_ID_BYTES = 8'h06;
  localparam logic [7:0]  DESC_CNT_MAX  = 8'hff;
  localparam int          IRQ_W         = 6;
endpackage

// [test/ubc_host_model.sv]
`timescale 1ns/10ps
module ubc_host_model (
  input  wire logic        clk_sys_in,
  input  wire logic        ready_in,
  input  wire logic        int_n_in,
  input  wire logic [15:0] data_in,
  output logic             cs_n_out,
  output logic             wr_n_out,
  output logic             rd_n_out,
  output logic             oe_n_out,
  output logic      [2:0]  fifo_select_out,
  output logic      [15:0] host_data_bus_out,
  output logic             timeout_out
);
  initial begin
    {cs_n_out, wr_n_out, rd_n_out, oe_n_out} = 4'hf;
    fifo_select_out = 3'h4;
    host_data_bus_out = 16'h0000;
    timeout_out = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  // Bounded poll; a stuck pin raises the timeout flag
  task automatic wait_lvl(input bit on_int, input logic v);
    int i;
    for (i = 0; i < 40 && (on_int ? int_n_in : ready_in) !== v; i++)
      cyc(1);
    if (i == 40) timeout_out = 1'b1;
  endtask
  // Select and data held well past the strobe end
  task automatic strobe(input logic [2:0] sel, input logic [15:0] d,
                        input bit rd);
    fifo_select_out = sel;
    host_data_bus_out = d;
    cs_n_out = 1'b0;
    cyc(2);
    if (rd) rd_n_out = 1'b0;
    else wr_n_out = 1'b0;
    cyc(6);
    {wr_n_out, rd_n_out} = 2'h3;
    cyc(5);
    cs_n_out = 1'b1;
    host_data_bus_out = ~d; // Released bus never keeps its last value
    cyc(6);
  endtask
  task automatic cmd(input logic [7:0] b);
    wait_lvl(1'b0, 1'b1);
    strobe(3'h4, {8'h00, b}, 1'b0);
  endtask
  task automatic reg_write(input logic [5:0] a, input logic [7:0] v);
    cmd({2'b10, a});
    cmd({4'h7, v[7:4]});
    cmd({4'h5, v[3:0]});
  endtask
  task automatic reg_read(input logic [5:0] a, output logic [7:0] v);
    cmd({2'b11, a});
    wait_lvl(1'b1, 1'b0);
    {cs_n_out, oe_n_out} = 2'h0;
    cyc(6);
    v = data_in[7:0];
    strobe(3'h4, 16'h0000, 1'b1);
    oe_n_out = 1'b1;
  endtask
endmodule

// [test/tb.sv]
`timescale 1ns/10ps
module tb;
  import ubc_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_in     = 1'b1;
  logic        cs_n, wr_n, rd_n, oe_n, boe, rdy, int_n, fwr, frd, dflt, tmo;
  logic [2:0]  sel;
  logic [1:0]  fsel, c_sel;
  logic [5:0]  ev         = 6'h00;
  logic [7:0]  ifcfg, rv;
  logic [15:0] bus_m, bus_d, fwd, c_wd, c_rd;
  logic [15:0] fdat       = 16'h1234;
  logic        c_oe       = 1'b0;
  logic        c_lo       = 1'b0;
  int          n_tests    = 0;
  int          bad_count  = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  ubc_command_port dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .oe_n_in(oe_n),
    .fifo_select_in(sel), .host_data_bus_in(bus_m),
    .host_data_bus_out(bus_d), .host_data_bus_oe_out(boe),
    .ready_out(rdy), .int_n_out(int_n), .usb_event_in(ev),
    .fifo_wr_out(fwr), .fifo_rd_out(frd), .fifo_sel_out(fsel),
    .fifo_wr_data_out(fwd), .fifo_rd_data_in(fdat),
    .interface_configuration_out(ifcfg), .default_config_out(dflt));
  ubc_host_model host (.clk_sys_in(clk_sys_in), .ready_in(rdy),
    .int_n_in(int_n), .data_in(bus_d), .cs_n_out(cs_n), .wr_n_out(wr_n),
    .rd_n_out(rd_n), .oe_n_out(oe_n), .fifo_select_out(sel),
    .host_data_bus_out(bus_m), .timeout_out(tmo));
  // FIFO pulses last one cycle, so latch them as they pass
  always @(posedge clk_sys_in) begin
    if (fwr === 1'b1) {c_sel, c_wd} <= {fsel, fwd};
    if (frd === 1'b1) {c_sel, c_rd} <= {fsel, bus_d};
    if (boe === 1'b1) c_oe <= 1'b1;
    if (rdy === 1'b0) c_lo <= 1'b1;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches %0d checks %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge tmo) begin
    bad_count++;
    finish_test();
  end
  task automatic pulse_ev(input logic [5:0] e);
    ev = e;
    @(negedge clk_sys_in);
    ev = 6'h00;
    repeat (4) @(negedge clk_sys_in);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_in);
    rst_in = 1'b0;
    chk({rdy, int_n, boe, dflt, ifcfg}, {4'hd, IFCFG_RST});
    host.cmd(8'h81);
    chk(c_lo, 1'b1);
    host.cmd(8'h73);
    chk(ifcfg, IFCFG_RST);
    host.cmd(8'h56);
    chk(ifcfg, 8'h36);
    host.reg_read(IFCFG_ADR, rv);
    chk({rv, int_n}, {8'h36, 1'b1});
    chk(c_oe, 1'b1);
    host.reg_write(IRQ_EN_ADR, 8'h04);
    host.reg_read(IFCFG_ADR, rv);
    chk(rv, 8'h36);
    pulse_ev(6'h02);
    chk(int_n, 1'b1);
    pulse_ev(6'h04);
    chk({int_n, bus_d[5:0]}, {1'b0, 6'h06});
    host.strobe(3'h4, 16'h0000, 1'b1);
    chk(int_n, 1'b1);
    host.strobe(3'h2, 16'ha5c3, 1'b0);
    chk({c_sel, c_wd}, {2'h2, 16'ha5c3});
    host.strobe(3'h1, 16'h0000, 1'b1);
    chk({c_sel, c_rd}, {2'h1, 16'h1234});
    host.strobe(3'h6, 16'h0081, 1'b0);
    chk({c_wd, rdy}, {16'ha5c3, 1'b1});
    host.cmd(8'h79);
    host.cmd(8'h58);
    chk(ifcfg, 8'h36);
    pulse_ev(6'h01);
    host.reg_read(IRQ_STAT_ADR, rv);
    chk({rv, int_n}, {8'h01, 1'b1});
    for (int i = 0; i <= DESC_ID_BYTES; i++) begin
      chk(dflt, 1'b1);
      host.reg_write(DESC_ADR, 8'h5a);
    end
    chk(dflt, 1'b0);
    finish_test();
  end
endmodule
